/* File: dv/dcp_ctrl_model.sv */
// Memory controller model driving the command pins on the link clock
`timescale 1ns/1ns
module dcp_ctrl_model
  import dcp_pkg::*;
(
  input  wire logic ck_i,
  output dcp_pins_t pins_o
);
  initial begin
    pins_o = '0;
    {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = 4'hf;
  end
  // Pins change on the fall, centred on the capturing rise
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(negedge ck_i);
    {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = c;
    pins_o.ba = b;
    pins_o.addr = a;
    @(negedge ck_i);
    pins_o.cs_n = 1'b1; // Own rank deselected between commands
    pins_o.addr = ~a; // Released bus must not echo the old value
  endtask
  // Refresh with CKE falling at the same rise enters self refresh
  task automatic sre;
    @(negedge ck_i);
    {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = {1'b0, CODE_REF};
    pins_o.cke = 1'b0;
    @(negedge ck_i);
    pins_o.cs_n = 1'b1;
  endtask
  // Raises CKE at once, usable while the link clock is stopped
  task automatic wake;
    pins_o.cke = 1'b1;
  endtask
  task automatic lvl(input logic k, input logic o, input logic [1:0] m, input logic [15:0] d);
    @(negedge ck_i);
    pins_o.cke = k;
    pins_o.odt = o;
    pins_o.dm = m;
    pins_o.dq = d;
  endtask
endmodule

/* File: dv/dcp_top_bench.sv */
// Self-checking bench of the command pin interface
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
`define WT(c, s) for (int i = 0; i < 30 && (s) !== 1'b1; i++) @(negedge c);
module dcp_top_bench
  import dcp_pkg::*;
;
  logic clk_i, rst_n_i, ck_i;
  logic [15:0] rd_data_i, dq_o, wr_data_o;
  logic [1:0] dqs_o, dqs_n_o, wr_be_o;
  logic dq_oe_o, dqs_oe_o, dqs_n_oe_o, arr_valid_o, wr_beat_o, term_en_o;
  logic clk_run_o, self_refresh_o, mode_wr_o, ck_en;
  logic [7:0] bank_open_o;
  dcp_acc_t arr_o;
  dcp_pwr_t pwr_o;
  dcp_mode_t mode_o;
  dcp_pins_t p;
  int err_total, num_checks, cyc;
  dcp_ctrl_model m (.ck_i(ck_i), .pins_o(p));
  dcp_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ck_i(ck_i), .cs_n_i(p.cs_n),
    .ras_n_i(p.ras_n), .cas_n_i(p.cas_n), .we_n_i(p.we_n), .cke_i(p.cke),
    .odt_i(p.odt), .ba_i(p.ba), .addr_i(p.addr), .dq_i(p.dq), .dm_i(p.dm),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o),
    .dqs_n_o(dqs_n_o), .dqs_n_oe_o(dqs_n_oe_o), .rd_data_i(rd_data_i),
    .arr_valid_o(arr_valid_o), .arr_o(arr_o), .wr_beat_o(wr_beat_o),
    .wr_data_o(wr_data_o), .wr_be_o(wr_be_o), .term_en_o(term_en_o),
    .clk_run_o(clk_run_o), .pwr_o(pwr_o), .bank_open_o(bank_open_o),
    .self_refresh_o(self_refresh_o), .mode_wr_o(mode_wr_o), .mode_o(mode_o));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Link clock offset so its edges never meet the core clock's
  // Stoppable, so self refresh exit is shown with no link clock
  initial begin
    ck_i = 1'b0;
    ck_en = 1'b1;
    #13;
    forever #40 ck_i = ck_en ? ~ck_i : ck_i;
  end
  // Fresh array word every cycle, so each read beat is distinct
  always @(negedge ck_i) rd_data_i <= rd_data_i + 16'h1111;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic t_act;
    m.cmd({1'b1, CODE_ACT}, 3'h2, 14'h0777);
    m.cmd({1'b0, CODE_ACT}, 3'h5, 14'h1234);
    @(negedge ck_i);
    `CHK(bank_open_o, 8'h20)
    $display("done act");
  endtask
  task automatic t_rd;
    m.cmd({1'b0, CODE_RD}, 3'h5, 14'h0408);
    `WT(ck_i, arr_valid_o)
    `CHK(arr_o.row, 14'h1234)
    `CHK(arr_o.bank, 3'h5)
    `CHK(arr_o.ap, 1'b1)
    `WT(ck_i, dq_oe_o)
    `CHK(dq_o, rd_data_i)
    `CHK(dqs_o, 2'h3)
    `CHK(dqs_n_o, 2'h0)
    `CHK(dqs_oe_o, 1'b1)
    `CHK(dqs_n_oe_o, 1'b1)
    @(negedge ck_i);
    `CHK(dq_o, rd_data_i)
    `CHK(dqs_o, 2'h0)
    repeat (6) @(negedge ck_i);
    `CHK(bank_open_o, 8'h00)
    `CHK(dq_oe_o, 1'b0)
    $display("done read");
  endtask
  task automatic t_wr;
    m.cmd({1'b0, CODE_ACT}, 3'h3, 14'h0007);
    m.lvl(1'b1, 1'b0, 2'h1, 16'hc3a5);
    m.cmd({1'b0, CODE_WR}, 3'h3, 14'h0010);
    `WT(ck_i, arr_valid_o)
    `CHK(arr_o.wr, 1'b1)
    `CHK(arr_o.row, 14'h0007)
    `CHK(arr_o.col, 14'h0010)
    `WT(ck_i, wr_beat_o)
    `CHK(wr_be_o, 2'h2)
    `CHK(wr_data_o, 16'hc3a5)
    repeat (6) @(negedge ck_i);
    m.cmd({1'b0, CODE_ACT}, 3'h0, 14'h0001);
    m.cmd({1'b0, CODE_PRE}, 3'h3, 14'h0000);
    @(negedge ck_i);
    `CHK(bank_open_o, 8'h01)
    m.cmd({1'b0, CODE_PRE}, 3'h6, 14'h0400);
    @(negedge ck_i);
    `CHK(bank_open_o, 8'h00)
    $display("done write");
  endtask
  task automatic t_lm;
    m.lvl(1'b1, 1'b1, 2'h0, 16'h0000);
    repeat (3) @(negedge ck_i);
    `CHK(term_en_o, 1'b0)
    m.cmd({1'b0, CODE_LM}, 3'h1, 14'h0404);
    `WT(clk_i, mode_wr_o)
    `CHK(mode_o.sel, MR_EXT1)
    `CHK(mode_o.val, 14'h0404)
    repeat (3) @(negedge ck_i);
    `CHK(term_en_o, 1'b1)
    m.cmd({1'b0, CODE_RD}, 3'h0, 14'h0000);
    `WT(ck_i, dq_oe_o)
    `CHK(dqs_oe_o, 1'b1)
    `CHK(dqs_n_oe_o, 1'b0)
    repeat (6) @(negedge ck_i);
    $display("done mode");
  endtask
  task automatic t_pd;
    m.lvl(1'b0, 1'b0, 2'h0, 16'h0000);
    repeat (3) @(negedge ck_i);
    `CHK(pwr_o, PWR_PRE_PD)
    `CHK(clk_run_o, 1'b0)
    m.lvl(1'b1, 1'b0, 2'h0, 16'h0000);
    repeat (3) @(negedge ck_i);
    `CHK(pwr_o, PWR_ON)
    $display("done power");
  endtask
  task automatic t_sr;
    m.sre();
    repeat (3) @(negedge ck_i);
    `CHK(pwr_o, PWR_SELF_REF)
    `CHK(self_refresh_o, 1'b1)
    ck_en = 1'b0;
    repeat (2) @(negedge clk_i);
    m.wake();
    repeat (6) @(negedge clk_i);
    `CHK(self_refresh_o, 1'b0)
    `CHK(pwr_o, PWR_SELF_REF)
    ck_en = 1'b1;
    repeat (3) @(negedge ck_i);
    `CHK(pwr_o, PWR_ON)
    `CHK(clk_run_o, 1'b1)
    $display("done self refresh");
  endtask
  initial begin
    rst_n_i = 1'b0;
    rd_data_i = 16'h5aa5;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    m.lvl(1'b1, 1'b0, 2'h0, 16'h0000);
    repeat (3) @(posedge ck_i);
    t_act();
    t_rd();
    t_wr();
    t_lm();
    t_pd();
    t_sr();
    give_verdict();
  end
endmodule

/* File: shared/dcp_pkg.sv */
// Constants and types of the DDR2 command, address and control pin interface
package dcp_pkg;

  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int NBANK  = 8;
  localparam int DQ_W   = 16;
  localparam int DM_W   = 2;
  localparam int BYTE_W = 8;

  localparam int AP_BIT           = 10;
  localparam int EMR_RTT_LO_BIT   = 2;
  localparam int EMR_RTT_HI_BIT   = 6;
  localparam int EMR_DQSN_DIS_BIT = 10;

  localparam logic [1:0]        MR_EXT1  = 2'h1;
  localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;

  // {RAS#, CAS#, WE#} with CS# low
  localparam logic [2:0] CODE_LM  = 3'h0;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_ACT = 3'h3;
  localparam logic [2:0] CODE_WR  = 3'h4;
  localparam logic [2:0] CODE_RD  = 3'h5;

  localparam logic [2:0] RD_LAT_CYC  = 3'h3;
  localparam logic [2:0] WR_LAT_CYC  = 3'h2;
  localparam logic [2:0] BURST_BEATS = 3'h4;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_LM, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD
  } dcp_cmd_t;

  typedef enum logic [1:0] {
    PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF
  } dcp_pwr_t;

  typedef enum logic [2:0] {
    DT_IDLE, DT_RD_WAIT, DT_RD_BURST, DT_WR_WAIT, DT_WR_BURST
  } dcp_dt_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic              odt;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq;
    logic [DM_W-1:0]   dm;
  } dcp_pins_t;

  typedef struct packed {
    logic              wr;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic              ap;
  } dcp_acc_t;

  typedef struct packed {
    logic [1:0]        sel;
    logic [ADDR_W-1:0] val;
  } dcp_mode_t;

endpackage

/* File: verilog/dcp_row_mem.sv */
// Open-row table, one entry per bank, registered read
`timescale 1ns/1ns
module dcp_row_mem
  import dcp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_en_i,
  input  wire logic [BANK_W-1:0] wr_addr_i,
  input  wire logic [ADDR_W-1:0] wr_data_i,
  input  wire logic [BANK_W-1:0] rd_addr_i,
  output logic      [ADDR_W-1:0] rd_data_o
);

  logic [ADDR_W-1:0] row_mem [NBANK];
  logic [ADDR_W-1:0] rd_data_reg;
  logic [ADDR_W-1:0] rd_data_next;

  // Write-through so a same-cycle ACTIVATE is seen
  always_comb begin
    rd_data_next = row_mem[rd_addr_i];
    if (wr_en_i && (wr_addr_i == rd_addr_i)) begin
      rd_data_next = wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      row_mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= MODE_RST;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule

/* File: verilog/dcp_top.sv */
// DDR2 command pin interface: registration, decode, bank, power, data lanes
`timescale 1ns/1ns
module dcp_top
  import dcp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ck_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic              cke_i,
  input  wire logic              odt_i,
  input  wire logic [BANK_W-1:0] ba_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DQ_W-1:0]   dq_i,
  input  wire logic [DM_W-1:0]   dm_i,
  output logic      [DQ_W-1:0]   dq_o,
  output logic                   dq_oe_o,
  output logic      [DM_W-1:0]   dqs_o,
  output logic                   dqs_oe_o,
  output logic      [DM_W-1:0]   dqs_n_o,
  output logic                   dqs_n_oe_o,
  input  wire logic [DQ_W-1:0]   rd_data_i,
  output logic                   arr_valid_o,
  output dcp_acc_t               arr_o,
  output logic                   wr_beat_o,
  output logic      [DQ_W-1:0]   wr_data_o,
  output logic      [DM_W-1:0]   wr_be_o,
  output logic                   term_en_o,
  output logic                   clk_run_o,
  output dcp_pwr_t               pwr_o,
  output logic      [NBANK-1:0]  bank_open_o,
  output logic                   self_refresh_o,
  output logic                   mode_wr_o,
  output dcp_mode_t              mode_o
);

  function automatic dcp_cmd_t decode(input dcp_pins_t p);
    dcp_cmd_t c;
    c = CMD_NOP;
    if (!p.cs_n) begin
      case ({p.ras_n, p.cas_n, p.we_n})
        CODE_LM:  c = CMD_LM;
        CODE_REF: c = CMD_REF;
        CODE_PRE: c = CMD_PRE;
        CODE_ACT: c = CMD_ACT;
        CODE_WR:  c = CMD_WR;
        CODE_RD:  c = CMD_RD;
        default:  c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // ---------------- Link domain: pin register
  dcp_pins_t pins_reg;
  dcp_pins_t pins_next;

  always_comb begin
    pins_next = '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i,
                  cke: cke_i, odt: odt_i, ba: ba_i, addr: addr_i,
                  dq: dq_i, dm: dm_i};
  end

  // Every input caught at the rising crossing of the clock pair
  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_reg <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                    cke: 1'b0, odt: 1'b0, ba: '0, addr: '0, dq: '0, dm: '0};
    end else begin
      pins_reg <= pins_next;
    end
  end

  // ---------------- Link domain: decode, banks, power, mode registers
  dcp_cmd_t                      cmd_raw;
  dcp_cmd_t                      cmd;
  logic                          rtt_on;
  logic                          ap_done;
  logic      [BANK_W-1:0]        row_rd;
  logic      [ADDR_W-1:0]        row_q;

  dcp_pwr_t                      pwr_reg;
  dcp_pwr_t                      pwr_next;
  logic                          cke_prev_reg;
  logic                          cke_prev_next;
  logic      [NBANK-1:0]         open_reg;
  logic      [NBANK-1:0]         open_next;
  logic      [3:0][ADDR_W-1:0]   mr_reg;
  logic      [3:0][ADDR_W-1:0]   mr_next;
  logic                          term_reg;
  logic                          term_next;
  logic                          mode_tog_reg;
  logic                          mode_tog_next;
  dcp_mode_t                     mode_hold_reg;
  dcp_mode_t                     mode_hold_next;
  logic                          pend_reg;
  logic                          pend_next;
  dcp_acc_t                      pend_acc_reg;
  dcp_acc_t                      pend_acc_next;
  logic                          arr_valid_reg;
  logic                          arr_valid_next;
  dcp_acc_t                      arr_reg;
  dcp_acc_t                      arr_next;

  // Data path state, declared here for the bank logic
  dcp_dt_t                       dt_reg;
  logic      [2:0]               cnt_reg;
  logic                          ap_hold_reg;
  logic      [BANK_W-1:0]        bank_hold_reg;

  assign cmd_raw = decode(pins_reg);
  // Receivers off outside normal power state, so nothing decodes there
  assign cmd = (pwr_reg == PWR_ON && cke_prev_reg && pins_reg.cke) ?
               cmd_raw : CMD_NOP;
  assign rtt_on = mr_reg[MR_EXT1][EMR_RTT_LO_BIT] | mr_reg[MR_EXT1][EMR_RTT_HI_BIT];
  assign ap_done = (dt_reg == DT_RD_BURST || dt_reg == DT_WR_BURST) &&
                   cnt_reg == 3'h0 && ap_hold_reg;
  assign row_rd = pins_reg.ba;

  dcp_row_mem u_row_mem (
    .clk_i     (ck_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (cmd == CMD_ACT),
    .wr_addr_i (pins_reg.ba),
    .wr_data_i (pins_reg.addr),
    .rd_addr_i (row_rd),
    .rd_data_o (row_q)
  );

  always_comb begin
    pwr_next       = pwr_reg;
    cke_prev_next  = pins_reg.cke;
    open_next      = open_reg;
    mr_next        = mr_reg;
    mode_tog_next  = mode_tog_reg;
    mode_hold_next = mode_hold_reg;
    pend_next      = 1'b0;
    pend_acc_next  = pend_acc_reg;
    arr_valid_next = pend_reg;
    arr_next       = arr_reg;
    if (pend_reg) begin
      arr_next     = pend_acc_reg;
      arr_next.row = row_q;
    end
    // Auto precharge closes the row once the burst has ended
    if (ap_done) begin
      open_next[bank_hold_reg] = 1'b0;
    end
    case (cmd)
      CMD_ACT: open_next[pins_reg.ba] = 1'b1;
      CMD_PRE: begin
        if (pins_reg.addr[AP_BIT]) begin
          open_next = '0;
        end else begin
          open_next[pins_reg.ba] = 1'b0;
        end
      end
      CMD_LM: begin
        mr_next[pins_reg.ba[1:0]] = pins_reg.addr;
        mode_hold_next = '{sel: pins_reg.ba[1:0], val: pins_reg.addr};
        mode_tog_next  = ~mode_tog_reg;
      end
      CMD_RD, CMD_WR: begin
        if (dt_reg == DT_IDLE) begin
          pend_next     = 1'b1;
          pend_acc_next = '{wr: (cmd == CMD_WR), bank: pins_reg.ba, row: '0,
                            col: pins_reg.addr, ap: pins_reg.addr[AP_BIT]};
        end
      end
      default: ;
    endcase
    case (pwr_reg)
      PWR_ON: begin
        if (cke_prev_reg && !pins_reg.cke) begin
          if (cmd_raw == CMD_REF) begin
            pwr_next = PWR_SELF_REF;
          end else if (|open_reg) begin
            pwr_next = PWR_ACT_PD;
          end else begin
            pwr_next = PWR_PRE_PD;
          end
        end
      end
      PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF: begin
        if (pins_reg.cke) begin
          pwr_next = PWR_ON;
        end
      end
      default: pwr_next = PWR_ON;
    endcase
    // Termination receiver stays alive in power-down, not in self refresh
    term_next = pins_reg.odt && rtt_on && (pwr_reg != PWR_SELF_REF);
  end

  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_reg       <= PWR_ON;
      cke_prev_reg  <= 1'b0;
      open_reg      <= '0;
      mr_reg        <= '{default: MODE_RST};
      term_reg      <= 1'b0;
      mode_tog_reg  <= 1'b0;
      mode_hold_reg <= '0;
      pend_reg      <= 1'b0;
      pend_acc_reg  <= '0;
      arr_valid_reg <= 1'b0;
      arr_reg       <= '0;
    end else begin
      pwr_reg       <= pwr_next;
      cke_prev_reg  <= cke_prev_next;
      open_reg      <= open_next;
      mr_reg        <= mr_next;
      term_reg      <= term_next;
      mode_tog_reg  <= mode_tog_next;
      mode_hold_reg <= mode_hold_next;
      pend_reg      <= pend_next;
      pend_acc_reg  <= pend_acc_next;
      arr_valid_reg <= arr_valid_next;
      arr_reg       <= arr_next;
    end
  end

  // ---------------- Link domain: data lanes
  // One beat per clock cycle; a burst issued while busy is dropped
  dcp_dt_t                 dt_next;
  logic      [2:0]         cnt_next;
  logic                    ap_hold_next;
  logic      [BANK_W-1:0]  bank_hold_next;
  logic      [DQ_W-1:0]    dq_reg;
  logic      [DQ_W-1:0]    dq_next;
  logic                    dq_oe_reg;
  logic                    dq_oe_next;
  logic      [DM_W-1:0]    dqs_reg;
  logic      [DM_W-1:0]    dqs_next;
  logic                    dqs_n_oe_reg;
  logic                    dqs_n_oe_next;
  logic      [DM_W-1:0]    dqs_n_reg;
  logic      [DM_W-1:0]    dqs_n_next;
  logic                    wr_beat_reg;
  logic                    wr_beat_next;
  logic      [DQ_W-1:0]    wr_data_reg;
  logic      [DQ_W-1:0]    wr_data_next;
  logic      [DM_W-1:0]    wr_be_reg;
  logic      [DM_W-1:0]    wr_be_next;
  logic      [DM_W-1:0]    lane_be;

  // Byte lane gating, one mask bit per byte
  genvar gi;
  generate
    for (gi = 0; gi < DM_W; gi++) begin : g_lane
      assign lane_be[gi] = ~pins_reg.dm[gi];
    end
  endgenerate

  always_comb begin
    dt_next        = dt_reg;
    cnt_next       = cnt_reg;
    ap_hold_next   = ap_hold_reg;
    bank_hold_next = bank_hold_reg;
    dq_next        = dq_reg;
    dq_oe_next     = 1'b0;
    dqs_next       = '0;
    wr_beat_next   = 1'b0;
    wr_data_next   = wr_data_reg;
    wr_be_next     = '0;
    case (dt_reg)
      DT_IDLE: begin
        if (cmd == CMD_RD || cmd == CMD_WR) begin
          dt_next        = (cmd == CMD_RD) ? DT_RD_WAIT : DT_WR_WAIT;
          cnt_next       = ((cmd == CMD_RD) ? RD_LAT_CYC : WR_LAT_CYC) - 3'h1;
          ap_hold_next   = pins_reg.addr[AP_BIT];
          bank_hold_next = pins_reg.ba;
        end
      end
      DT_RD_WAIT, DT_WR_WAIT: begin
        if (cnt_reg == 3'h0) begin
          dt_next  = (dt_reg == DT_RD_WAIT) ? DT_RD_BURST : DT_WR_BURST;
          cnt_next = BURST_BEATS - 3'h1;
          if (dt_reg == DT_RD_WAIT) begin
            dq_next    = rd_data_i;
            dq_oe_next = 1'b1;
            dqs_next   = '1;
          end
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      DT_RD_BURST: begin
        // Data and strobe flip on the same edge: edge-aligned
        if (cnt_reg != 3'h0) begin
          dq_next    = rd_data_i;
          dq_oe_next = 1'b1;
          dqs_next   = ~dqs_reg;
          cnt_next   = cnt_reg - 3'h1;
        end else begin
          dt_next = DT_IDLE;
        end
      end
      DT_WR_BURST: begin
        wr_beat_next = 1'b1;
        wr_data_next = pins_reg.dq;
        wr_be_next   = lane_be;
        if (cnt_reg == 3'h0) begin
          dt_next = DT_IDLE;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      default: dt_next = DT_IDLE;
    endcase
    dqs_n_oe_next = dq_oe_next && !mr_reg[MR_EXT1][EMR_DQSN_DIS_BIT];
    // Own flop, so the complement pin is not an inverter after a register
    dqs_n_next    = ~dqs_next;
  end

  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dt_reg        <= DT_IDLE;
      cnt_reg       <= 3'h0;
      ap_hold_reg   <= 1'b0;
      bank_hold_reg <= '0;
      dq_reg        <= '0;
      dq_oe_reg     <= 1'b0;
      dqs_reg       <= '0;
      dqs_n_oe_reg  <= 1'b0;
      dqs_n_reg     <= '1;
      wr_beat_reg   <= 1'b0;
      wr_data_reg   <= '0;
      wr_be_reg     <= '0;
    end else begin
      dt_reg        <= dt_next;
      cnt_reg       <= cnt_next;
      ap_hold_reg   <= ap_hold_next;
      bank_hold_reg <= bank_hold_next;
      dq_reg        <= dq_next;
      dq_oe_reg     <= dq_oe_next;
      dqs_reg       <= dqs_next;
      dqs_n_oe_reg  <= dqs_n_oe_next;
      dqs_n_reg     <= dqs_n_next;
      wr_beat_reg   <= wr_beat_next;
      wr_data_reg   <= wr_data_next;
      wr_be_reg     <= wr_be_next;
    end
  end

  // ---------------- Core domain
  // Raw pin CKE is watched here, so exit shows without any link clock
  logic       cke_s1_reg;
  logic       cke_s2_reg;
  logic       sr_s1_reg;
  logic       sr_s2_reg;
  logic [2:0] tog_s_reg;
  logic       self_ref_reg;
  logic       self_ref_next;
  logic       mode_wr_reg;
  logic       mode_wr_next;
  dcp_mode_t  mode_reg;
  dcp_mode_t  mode_next;

  always_comb begin
    self_ref_next = sr_s2_reg && !cke_s2_reg;
    mode_wr_next  = tog_s_reg[1] ^ tog_s_reg[2];
    // Held word is stable: mode loads are far apart on the link
    mode_next     = mode_wr_next ? mode_hold_reg : mode_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cke_s1_reg   <= 1'b0;
      cke_s2_reg   <= 1'b0;
      sr_s1_reg    <= 1'b0;
      sr_s2_reg    <= 1'b0;
      tog_s_reg    <= 3'h0;
      self_ref_reg <= 1'b0;
      mode_wr_reg  <= 1'b0;
      mode_reg     <= '0;
    end else begin
      cke_s1_reg   <= cke_i;
      cke_s2_reg   <= cke_s1_reg;
      sr_s1_reg    <= (pwr_reg == PWR_SELF_REF);
      sr_s2_reg    <= sr_s1_reg;
      tog_s_reg    <= {tog_s_reg[1:0], mode_tog_reg};
      self_ref_reg <= self_ref_next;
      mode_wr_reg  <= mode_wr_next;
      mode_reg     <= mode_next;
    end
  end

  assign dq_o           = dq_reg;
  assign dq_oe_o        = dq_oe_reg;
  assign dqs_o          = dqs_reg;
  assign dqs_oe_o       = dq_oe_reg;
  assign dqs_n_o        = dqs_n_reg;
  assign dqs_n_oe_o     = dqs_n_oe_reg;
  assign arr_valid_o    = arr_valid_reg;
  assign arr_o          = arr_reg;
  assign wr_beat_o      = wr_beat_reg;
  assign wr_data_o      = wr_data_reg;
  assign wr_be_o        = wr_be_reg;
  assign term_en_o      = term_reg;
  assign clk_run_o      = pins_reg.cke;
  assign pwr_o          = pwr_reg;
  assign bank_open_o    = open_reg;
  assign self_refresh_o = self_ref_reg;
  assign mode_wr_o      = mode_wr_reg;
  assign mode_o         = mode_reg;

  // ---------------- Assertions
  AST_CS_MASKS: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    pins_reg.cs_n && !ap_done |=> open_reg == $past(open_reg) && !pend_reg)
    else $error("command decoded with chip select high");

  AST_ACT_OPENS: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    cmd == CMD_ACT |=> open_reg[$past(pins_reg.ba)])
    else $error("activate did not open addressed bank");

  AST_PRE_ALL: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    cmd == CMD_PRE && pins_reg.addr[AP_BIT] |=> open_reg == '0)
    else $error("precharge all left a bank open");

  AST_PRE_ONE: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    cmd == CMD_PRE && !pins_reg.addr[AP_BIT] && !ap_done |=>
      !open_reg[$past(pins_reg.ba)] &&
      $countones(open_reg) + 1 >= $countones($past(open_reg)))
    else $error("single bank precharge wrong");

  AST_LM_LOADS: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    cmd == CMD_LM |=> mr_reg[$past(pins_reg.ba[1:0])] == $past(pins_reg.addr))
    else $error("mode register not loaded from address");

  AST_ODT_IGNORED: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    !rtt_on ##1 !rtt_on |-> !term_en_o)
    else $error("termination on while disabled by mode");

  AST_SR_ENTRY: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    pwr_reg == PWR_ON && cke_prev_reg && !pins_reg.cke && cmd_raw == CMD_REF
      |=> pwr_reg == PWR_SELF_REF)
    else $error("self refresh not entered");

  AST_PD_GATED: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    pwr_reg != PWR_ON |=> mr_reg == $past(mr_reg) && !pend_reg)
    else $error("command decoded during power-down");

  AST_RD_LATENCY: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    cmd == CMD_RD && dt_reg == DT_IDLE |-> ##1 !dq_oe_o ##3 dq_oe_o [*4] ##1 !dq_oe_o)
    else $error("read burst timing wrong");

  AST_WR_MASK: assert property (@(posedge ck_i) disable iff (!rst_n_i)
    wr_beat_o |-> wr_be_o == ~$past(pins_reg.dm) && wr_data_o == $past(pins_reg.dq))
    else $error("write byte enable not from mask");

  AST_SR_EXIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cke_s2_reg |=> !self_refresh_o)
    else $error("self refresh not left on async clock enable");

endmodule
